/* logic/srpd_pkg.sv */
// Purpose: Shared constants for the self-refresh, power-down and ODT block
// Assumes: 10 MHz core clock, AXI4-Lite register access, 32-bit data
// Notes:   Command pins sampled at the rising edge of CLK_I
package srpd_pkg;

  // ===========================================================================
  // Register map (byte addresses) and AXI responses
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  REG_STATUS  = 4'h0;
  localparam logic [3:0]  REG_REFCFG  = 4'h4;
  localparam logic [3:0]  REG_MODE    = 4'h8;
  localparam logic [3:0]  REG_REFCNT  = 4'hC;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ===========================================================================
  // Timing: figures in their own unit, cycle counts derived from the clock
  localparam int          CLK_PERIOD_PS = 100000;
  localparam int          T_REFI_NS     = 7800;
  localparam int          T_CKE_NS      = 5;
  localparam int          T_CPDED_TCK   = 1;
  localparam int          REFI_CYC_I    = (T_REFI_NS * 1000) / CLK_PERIOD_PS;
  localparam int          CKE_CYC_I     = (T_CKE_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [15:0] REFI_CYC      = 16'(REFI_CYC_I);
  localparam logic [15:0] SRE_REF_CYC   = (CKE_CYC_I < 1) ? 16'h0001
                                          : 16'(CKE_CYC_I);
  localparam logic [3:0]  CPDED_CYC     = 4'(T_CPDED_TCK);

  // ===========================================================================
  // STATUS and MODE field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_DLL_BIT   = 4;
  localparam int ST_RTT_BIT   = 5;
  localparam int ST_RX_BIT    = 6;
  localparam int ST_BANK_LSB  = 8;
  localparam int MD_A12_BIT   = 0;
  localparam int MD_DLLD_BIT  = 1;
  localparam int MD_NOM_LSB   = 4;
  localparam int MD_WR_LSB    = 8;

  // ===========================================================================
  // Command bus: address bit positions, mode register select, encodings
  localparam int         A_DLL_DIS = 0;
  localparam int         A_NOM0    = 2;
  localparam int         A_NOM1    = 6;
  localparam int         A_NOM2    = 9;
  localparam int         A_WR0     = 9;
  localparam int         A_WR1     = 10;
  localparam int         A_ALLBANK = 10;
  localparam int         A_PD_DLL  = 12;
  localparam logic [2:0] MR_SEL0   = 3'h0;
  localparam logic [2:0] MR_SEL1   = 3'h1;
  localparam logic [2:0] MR_SEL2   = 3'h2;
  localparam logic [3:0] CMD_MRS   = 4'h0;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_NOP   = 4'h7;

  // ===========================================================================
  // Power states
  typedef enum logic [2:0] {
    ST_RST,
    ST_IDLE,
    ST_SREF,
    ST_PDN_PRE,
    ST_PDN_ACT
  } srpd_state_t;

endpackage

/* logic/srpd_timer.sv */
// Purpose: Loadable down-counter giving a one-cycle pulse at expiry
// Assumes: Synchronous active-high reset
// Notes:   A load of zero never expires
`timescale 1ns/1ps
module srpd_timer #(
  parameter int W = 16
) (
  input  wire logic         clk_i,   // Core clock
  input  wire logic         srst_i,  // Synchronous reset
  input  wire logic         load_i,  // Load count this cycle
  input  wire logic [W-1:0] value_i, // Cycles until expiry
  output logic              done_o   // Expiry pulse
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } srpd_tmr_t;

  srpd_tmr_t t_reg;
  srpd_tmr_t t_next;

  // ===========================================================================
  // Next state: load wins over counting
  always_comb begin
    t_next      = t_reg;
    t_next.done = 1'b0;
    if (load_i) begin
      t_next.cnt = value_i;
    end else if (t_reg.cnt != '0) begin
      t_next.cnt = t_reg.cnt - W'(1);
      if (t_reg.cnt == W'(1)) begin
        t_next.done = 1'b1;
      end
    end
  end

  // Register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign done_o = t_reg.done;

endmodule

/* logic/srpd_core.sv */
// Purpose: Power-state and termination control of a DDR3 SDRAM die
// Assumes: Command pins synchronous to CLK_I; AXI4-Lite on the same clock
// Notes:   Registers give status, mode image, refresh interval and count
//
// Notes on behaviour
// - Self-refresh entry: CS, RAS, CAS, CKE low, WE high at an edge.
// - Device stays in self-refresh while clock enable stays low.
// - DLL off in self-refresh; on exit re-enabled with a DLL reset.
// - In self-refresh only clock enable and reset are observed.
// - At least one internal refresh starts within tCKE after entry; here INT_REF_O pulses two clock cycles after the entry edge.
// - Power-down is precharge type if all banks closed, else active.
// - Receivers switch off tCPDED after power-down entry.
// - Active and A12=1 keep DLL on; precharge with A12=0 turns it off.
// - Reset pin low leaves power-down into the reset state.
// - Termination off in self-refresh and when mode bits disable it.
// - Termination follows the ODT pin when any RTT mode bit is set.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module srpd_core #(
  parameter int BA_W = 3,
  parameter int A_W  = 16
) (
  input  wire logic                       CLK_I,           // Core clock
  input  wire logic                       SRST_I,          // Sync reset
  input  wire logic                       CKE_I,           // Clock enable
  input  wire logic                       CS_N_I,          // Chip select
  input  wire logic                       RAS_N_I,         // Row strobe
  input  wire logic                       CAS_N_I,         // Column strobe
  input  wire logic                       WE_N_I,          // Write enable
  input  wire logic [BA_W-1:0]            BA_I,            // Bank address
  input  wire logic [A_W-1:0]             ADDR_I,          // Address bus
  input  wire logic                       ODT_I,           // Termination pin
  input  wire logic                       RESET_N_I,       // Device reset
  output logic                            RTT_ON_O,        // Termination on
  output logic                            DLL_ON_O,        // DLL running
  output logic                            DLL_RST_O,       // DLL reset pulse
  output logic                            INT_REF_O,       // Internal refresh
  output logic                            RX_EN_O,         // Cmd receivers
  output logic [2:0]                      PSTATE_O,        // Power state
  input  wire logic [srpd_pkg::ADDR_W-1:0] S_AXI_AWADDR_I, // Write address
  input  wire logic                       S_AXI_AWVALID_I, // AW valid
  output logic                            S_AXI_AWREADY_O, // AW ready
  input  wire logic [31:0]                S_AXI_WDATA_I,   // Write data
  input  wire logic [3:0]                 S_AXI_WSTRB_I,   // Byte strobes
  input  wire logic                       S_AXI_WVALID_I,  // W valid
  output logic                            S_AXI_WREADY_O,  // W ready
  output logic [1:0]                      S_AXI_BRESP_O,   // Write response
  output logic                            S_AXI_BVALID_O,  // B valid
  input  wire logic                       S_AXI_BREADY_I,  // B ready
  input  wire logic [srpd_pkg::ADDR_W-1:0] S_AXI_ARADDR_I, // Read address
  input  wire logic                       S_AXI_ARVALID_I, // AR valid
  output logic                            S_AXI_ARREADY_O, // AR ready
  output logic [31:0]                     S_AXI_RDATA_O,   // Read data
  output logic [1:0]                      S_AXI_RRESP_O,   // Read response
  output logic                            S_AXI_RVALID_O,  // R valid
  input  wire logic                       S_AXI_RREADY_I   // R ready
);

  localparam int NB = 1 << BA_W;

  typedef struct packed {
    srpd_pkg::srpd_state_t        state;
    logic [NB-1:0]                bank_open;
    logic [3:0]                   cpded;
    logic                         mr0_a12;
    logic                         mr1_dll_dis;
    logic [2:0]                   mr1_nom;
    logic [1:0]                   mr2_wr;
    logic                         dll_on;
    logic                         dll_rst;
    logic                         rtt_on;
    logic                         rx_en;
    logic                         int_ref;
    logic [15:0]                  ref_cnt;
    logic [15:0]                  refi_cfg;
    logic                         awready;
    logic                         wready;
    logic [srpd_pkg::ADDR_W-1:0]  waddr;
    logic [31:0]                  wdata;
    logic [3:0]                   wstrb;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         arready;
    logic                         rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
  } srpd_regs_t;

  srpd_regs_t r_reg;
  srpd_regs_t r_next;

  logic [3:0]    cmd;
  logic          is_nop;
  logic          cmd_ok;
  logic          enter_sr;
  logic          enter_pd;
  logic          rtt_en;
  logic          tmr_load;
  logic [15:0]   tmr_val;
  logic          tmr_done;
  logic [NB-1:0] act_hit;
  logic [NB-1:0] pre_hit;

  // ===========================================================================
  // Command decode from the sampled pins
  assign cmd      = {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I};
  assign is_nop   = CS_N_I | (cmd == srpd_pkg::CMD_NOP);
  assign cmd_ok   = (r_reg.state == srpd_pkg::ST_IDLE) & CKE_I & ~CS_N_I;
  assign enter_sr = (r_reg.state == srpd_pkg::ST_IDLE) & ~CKE_I
                    & (cmd == srpd_pkg::CMD_REF) & RESET_N_I;
  assign enter_pd = (r_reg.state == srpd_pkg::ST_IDLE) & ~CKE_I
                    & is_nop & RESET_N_I;
  assign rtt_en   = |{r_reg.mr1_nom, r_reg.mr2_wr};

  // Bank open tracking, one slice per bank
  for (genvar gi = 0; gi < NB; gi++) begin : g_bank
    assign act_hit[gi] = cmd_ok & (cmd == srpd_pkg::CMD_ACT)
                         & (BA_I == BA_W'(gi));
    assign pre_hit[gi] = cmd_ok & (cmd == srpd_pkg::CMD_PRE)
                         & (ADDR_I[srpd_pkg::A_ALLBANK]
                            | (BA_I == BA_W'(gi)));
  end

  // ===========================================================================
  // Internal refresh timer for self-refresh
  assign tmr_load = enter_sr
                    | (tmr_done & (r_reg.state == srpd_pkg::ST_SREF));
  assign tmr_val  = enter_sr ? srpd_pkg::SRE_REF_CYC : r_reg.refi_cfg;

  srpd_timer #(
    .W       (16)
  ) u_timer (
    .clk_i   (CLK_I),
    .srst_i  (SRST_I),
    .load_i  (tmr_load),
    .value_i (tmr_val),
    .done_o  (tmr_done)
  );

  // ===========================================================================
  // Next state: power states, mode image, termination, register bus
  always_comb begin
    r_next         = r_reg;
    r_next.int_ref = 1'b0;
    r_next.dll_rst = 1'b0;
    if (!RESET_N_I) begin
      // Reset pin overrides every power state
      r_next.state     = srpd_pkg::ST_RST;
      r_next.bank_open = '0;
      r_next.dll_on    = 1'b0;
      r_next.rx_en     = 1'b1;
      r_next.cpded     = '0;
    end else begin
      case (r_reg.state)
        srpd_pkg::ST_RST: begin
          r_next.state  = srpd_pkg::ST_IDLE;
          r_next.dll_on = ~r_reg.mr1_dll_dis;
        end
        srpd_pkg::ST_IDLE: begin
          if (enter_sr) begin
            r_next.state  = srpd_pkg::ST_SREF;
            r_next.dll_on = 1'b0;
            r_next.rx_en  = 1'b0;
          end else if (enter_pd) begin
            r_next.cpded = srpd_pkg::CPDED_CYC;
            if (|r_reg.bank_open) begin
              r_next.state = srpd_pkg::ST_PDN_ACT;
            end else begin
              r_next.state = srpd_pkg::ST_PDN_PRE;
              if (!r_reg.mr0_a12) begin
                r_next.dll_on = 1'b0;
              end
            end
          end else begin
            r_next.bank_open = (r_reg.bank_open | act_hit) & ~pre_hit;
            if (cmd_ok && cmd == srpd_pkg::CMD_MRS) begin
              if (BA_I == BA_W'(srpd_pkg::MR_SEL0)) begin
                r_next.mr0_a12 = ADDR_I[srpd_pkg::A_PD_DLL];
              end else if (BA_I == BA_W'(srpd_pkg::MR_SEL1)) begin
                r_next.mr1_dll_dis = ADDR_I[srpd_pkg::A_DLL_DIS];
                r_next.dll_on      = ~ADDR_I[srpd_pkg::A_DLL_DIS];
                r_next.mr1_nom     = {ADDR_I[srpd_pkg::A_NOM2],
                                      ADDR_I[srpd_pkg::A_NOM1],
                                      ADDR_I[srpd_pkg::A_NOM0]};
              end else if (BA_I == BA_W'(srpd_pkg::MR_SEL2)) begin
                r_next.mr2_wr = {ADDR_I[srpd_pkg::A_WR1],
                                 ADDR_I[srpd_pkg::A_WR0]};
              end
            end
          end
        end
        srpd_pkg::ST_SREF: begin
          // Only CKE is looked at; the command bus is ignored here
          if (CKE_I) begin
            r_next.state   = srpd_pkg::ST_IDLE;
            r_next.rx_en   = 1'b1;
            r_next.dll_on  = ~r_reg.mr1_dll_dis;
            r_next.dll_rst = ~r_reg.mr1_dll_dis;
          end
          if (tmr_done) begin
            r_next.int_ref = 1'b1;
            r_next.ref_cnt = r_reg.ref_cnt + 16'h0001;
          end
        end
        srpd_pkg::ST_PDN_PRE, srpd_pkg::ST_PDN_ACT: begin
          if (CKE_I) begin
            r_next.state  = srpd_pkg::ST_IDLE;
            r_next.rx_en  = 1'b1;
            r_next.cpded  = '0;
            r_next.dll_on = ~r_reg.mr1_dll_dis;
          end else if (r_reg.cpded != '0) begin
            r_next.cpded = r_reg.cpded - 4'h1;
            if (r_reg.cpded == 4'h1) begin
              r_next.rx_en = 1'b0;
            end
          end
        end
        default: begin
          r_next.state = srpd_pkg::ST_RST;
        end
      endcase
    end

    // Termination follows the pin unless disabled, in self-refresh or in the reset state
    r_next.rtt_on = RESET_N_I & ODT_I & rtt_en
                    & (r_next.state != srpd_pkg::ST_SREF)
                    & (r_next.state != srpd_pkg::ST_RST);

    // AXI write: address and data taken in either order
    if (S_AXI_AWVALID_I && r_reg.awready) begin
      r_next.awready = 1'b0;
      r_next.waddr   = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && r_reg.wready) begin
      r_next.wready = 1'b0;
      r_next.wdata  = S_AXI_WDATA_I;
      r_next.wstrb  = S_AXI_WSTRB_I;
    end
    if (!r_reg.awready && !r_reg.wready && !r_reg.bvalid) begin
      r_next.bvalid = 1'b1;
      r_next.bresp  = srpd_pkg::RESP_OKAY;
      if (r_reg.waddr == srpd_pkg::REG_REFCFG) begin
        if (r_reg.wstrb[0]) begin
          r_next.refi_cfg[7:0] = r_reg.wdata[7:0];
        end
        if (r_reg.wstrb[1]) begin
          r_next.refi_cfg[15:8] = r_reg.wdata[15:8];
        end
        if (r_next.refi_cfg == 16'h0000) begin
          r_next.refi_cfg = 16'h0001;
        end
      end else if (r_reg.waddr == srpd_pkg::REG_STATUS
                   || r_reg.waddr == srpd_pkg::REG_MODE
                   || r_reg.waddr == srpd_pkg::REG_REFCNT) begin
        r_next.bresp = srpd_pkg::RESP_OKAY;
      end else begin
        r_next.bresp = srpd_pkg::RESP_SLVERR;
      end
    end
    if (r_reg.bvalid && S_AXI_BREADY_I) begin
      r_next.bvalid  = 1'b0;
      r_next.awready = 1'b1;
      r_next.wready  = 1'b1;
    end

    // AXI read: one outstanding, answered the cycle after acceptance
    if (S_AXI_ARVALID_I && r_reg.arready) begin
      r_next.arready = 1'b0;
      r_next.rvalid  = 1'b1;
      r_next.rresp   = srpd_pkg::RESP_OKAY;
      r_next.rdata   = 32'h0000_0000;
      if (S_AXI_ARADDR_I == srpd_pkg::REG_STATUS) begin
        r_next.rdata[srpd_pkg::ST_STATE_LSB +: 3] = r_reg.state;
        r_next.rdata[srpd_pkg::ST_DLL_BIT]       = r_reg.dll_on;
        r_next.rdata[srpd_pkg::ST_RTT_BIT]       = r_reg.rtt_on;
        r_next.rdata[srpd_pkg::ST_RX_BIT]        = r_reg.rx_en;
        r_next.rdata[srpd_pkg::ST_BANK_LSB +: NB] = r_reg.bank_open;
      end else if (S_AXI_ARADDR_I == srpd_pkg::REG_REFCFG) begin
        r_next.rdata[15:0] = r_reg.refi_cfg;
      end else if (S_AXI_ARADDR_I == srpd_pkg::REG_MODE) begin
        r_next.rdata[srpd_pkg::MD_A12_BIT]      = r_reg.mr0_a12;
        r_next.rdata[srpd_pkg::MD_DLLD_BIT]     = r_reg.mr1_dll_dis;
        r_next.rdata[srpd_pkg::MD_NOM_LSB +: 3] = r_reg.mr1_nom;
        r_next.rdata[srpd_pkg::MD_WR_LSB +: 2]  = r_reg.mr2_wr;
      end else if (S_AXI_ARADDR_I == srpd_pkg::REG_REFCNT) begin
        r_next.rdata[15:0] = r_reg.ref_cnt;
      end else begin
        r_next.rresp = srpd_pkg::RESP_SLVERR;
      end
    end
    if (r_reg.rvalid && S_AXI_RREADY_I) begin
      r_next.rvalid  = 1'b0;
      r_next.arready = 1'b1;
    end
  end

  // ===========================================================================
  // State register
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      r_reg          <= '0;
      r_reg.state    <= srpd_pkg::ST_RST;
      r_reg.rx_en    <= 1'b1;
      r_reg.refi_cfg <= srpd_pkg::REFI_CYC;
      r_reg.awready  <= 1'b1;
      r_reg.wready   <= 1'b1;
      r_reg.arready  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign RTT_ON_O        = r_reg.rtt_on;
  assign DLL_ON_O        = r_reg.dll_on;
  assign DLL_RST_O       = r_reg.dll_rst;
  assign INT_REF_O       = r_reg.int_ref;
  assign RX_EN_O         = r_reg.rx_en;
  assign PSTATE_O        = r_reg.state;
  assign S_AXI_AWREADY_O = r_reg.awready;
  assign S_AXI_WREADY_O  = r_reg.wready;
  assign S_AXI_BVALID_O  = r_reg.bvalid;
  assign S_AXI_BRESP_O   = r_reg.bresp;
  assign S_AXI_ARREADY_O = r_reg.arready;
  assign S_AXI_RVALID_O  = r_reg.rvalid;
  assign S_AXI_RDATA_O   = r_reg.rdata;
  assign S_AXI_RRESP_O   = r_reg.rresp;

  // ===========================================================================
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  property p_sre;
    enter_sr |=> r_reg.state == srpd_pkg::ST_SREF;
  endproperty
  a_sre: assert property (p_sre)
    else $error("Self-refresh entry not taken");

  property p_sr_hold;
    (r_reg.state == srpd_pkg::ST_SREF) && !CKE_I && RESET_N_I
      |=> r_reg.state == srpd_pkg::ST_SREF;
  endproperty
  a_sr_hold: assert property (p_sr_hold)
    else $error("Self-refresh left with CKE low");

  property p_dll_sr;
    (r_reg.state == srpd_pkg::ST_SREF) && CKE_I && RESET_N_I
      && !r_reg.mr1_dll_dis |=> r_reg.dll_rst && r_reg.dll_on;
  endproperty
  a_dll_sr: assert property (p_dll_sr)
    else $error("No DLL reset on self-refresh exit");

  property p_int_ref;
    $rose(r_reg.state == srpd_pkg::ST_SREF) ##1
      (r_reg.state == srpd_pkg::ST_SREF) |=> r_reg.int_ref;
  endproperty
  a_int_ref: assert property (p_int_ref)
    else $error("No internal refresh after entry");

  property p_pd_kind;
    enter_pd && (|r_reg.bank_open) |=> r_reg.state == srpd_pkg::ST_PDN_ACT;
  endproperty
  a_pd_kind: assert property (p_pd_kind)
    else $error("Open bank but not active power-down");

  property p_rx_off;
    enter_pd ##1 (!CKE_I && RESET_N_I)[*2] |-> !r_reg.rx_en;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("Receivers still on in power-down");

  property p_dll_ppd;
    enter_pd && !(|r_reg.bank_open) && !r_reg.mr0_a12 |=> !r_reg.dll_on;
  endproperty
  a_dll_ppd: assert property (p_dll_ppd)
    else $error("DLL on in slow-exit power-down");

  property p_rst;
    !RESET_N_I |=> (r_reg.state == srpd_pkg::ST_RST) && !r_reg.rtt_on;
  endproperty
  a_rst: assert property (p_rst)
    else $error("Reset pin did not force reset state");

  property p_rtt_sr;
    (r_reg.state == srpd_pkg::ST_SREF) |-> !r_reg.rtt_on;
  endproperty
  a_rtt_sr: assert property (p_rtt_sr)
    else $error("Termination on in self-refresh");

  property p_rtt_pin;
    RESET_N_I && (r_reg.state == srpd_pkg::ST_IDLE) && !enter_sr
      |=> r_reg.rtt_on == ($past(ODT_I) && $past(rtt_en));
  endproperty
  a_rtt_pin: assert property (p_rtt_pin)
    else $error("Termination does not follow the pin");

endmodule

/* dv/srpd_ctl.sv */
// Purpose: Memory controller model driving the command pins
// Assumes: Pins change by non-blocking assignment after a rising edge
// Notes:   Command order and spacing are chosen by the calling test
`timescale 1ns/1ps
module srpd_ctl (
  input  wire logic   clk_i,   // Core clock
  output logic        cke_o,   // Clock enable
  output logic [3:0]  cmd_o,   // CS, RAS, CAS, WE, low true
  output logic [2:0]  ba_o,    // Bank address
  output logic [15:0] addr_o,  // Address bus
  output logic        odt_o,   // Termination request
  output logic        rst_n_o  // Device reset, active low
);
  // ==========================================================================
  // Idle pins at time zero: NOP, clock enabled, out of reset
  initial {cke_o, cmd_o, ba_o, addr_o, odt_o, rst_n_o} =
    {1'b1, srpd_pkg::CMD_NOP, 19'h0, 1'b0, 1'b1};
  // One command edge; pins then hold until the next call
  task automatic issue(input logic k, input logic [3:0] c, input logic o,
                       input logic [2:0] b, input logic [15:0] a);
    @(posedge clk_i);
    {cke_o, cmd_o, odt_o, ba_o, addr_o} <= {k, c, o, b, a};
  endtask
  // Device reset pin level
  task automatic set_rst(input logic v);
    @(posedge clk_i);
    rst_n_o <= v;
  endtask
endmodule

/* dv/tb.sv */
// Purpose: Self-checking bench for the power-state and termination block
// Assumes: 10 MHz clock, controller model on the command pins
// Notes:   Register bus driven by AXI4-Lite master tasks
`timescale 1ns/1ps
module tb;
  logic        clk_i, srst_i, awv, wv, bry, arv, rry, cke, odt, rst_n;
  logic        rtt, dll, dllr, iref, rx, awr, wr, bv, arr, rv;
  logic [3:0]  awa, ara, cmd;
  logic [31:0] wd, rdata;
  logic [2:0]  ba, pst;
  logic [15:0] addr;
  logic [1:0]  bresp, rresp;
  int          fail_count, num_checks;
  // ==========================================================================
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  srpd_ctl srpd_ctl_i (.clk_i(clk_i), .cke_o(cke), .cmd_o(cmd), .ba_o(ba),
    .addr_o(addr), .odt_o(odt), .rst_n_o(rst_n));
  srpd_core srpd_core_i (.CLK_I(clk_i), .SRST_I(srst_i), .CKE_I(cke),
    .CS_N_I(cmd[3]), .RAS_N_I(cmd[2]), .CAS_N_I(cmd[1]), .WE_N_I(cmd[0]),
    .BA_I(ba), .ADDR_I(addr), .ODT_I(odt), .RESET_N_I(rst_n),
    .RTT_ON_O(rtt), .DLL_ON_O(dll), .DLL_RST_O(dllr), .INT_REF_O(iref),
    .RX_EN_O(rx), .PSTATE_O(pst), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rry));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic cm(input logic k, input logic [3:0] c, input logic o,
                    input logic [2:0] b, input logic [15:0] a);
    srpd_ctl_i.issue(k, c, o, b, a);
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {awv, wv, bry, awa, wd} <= {3'b111, a, d};
    do begin
      @(posedge clk_i);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    bry <= 1'b0;
    chk("bresp", 32'(srpd_pkg::RESP_OKAY), 32'(bresp));
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, string nm);
    @(posedge clk_i);
    {arv, rry, ara} <= {2'b11, a};
    do begin
      @(posedge clk_i);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rry <= 1'b0;
    chk(nm, e, rdata);
    chk("rresp", 32'(srpd_pkg::RESP_OKAY), 32'(rresp));
  endtask
  task automatic rtt_case(input logic [2:0] b, input logic [15:0] a, e);
    cm(1'b1, srpd_pkg::CMD_MRS, 1'b0, b, a);
    cm(1'b1, srpd_pkg::CMD_NOP, 1'b1, 3'h0, 16'h0);
    step(1);
    chk("rtt", e, 32'(rtt));
  endtask
  // ==========================================================================
  // Self-refresh entry, ignored pins, internal refresh, exit
  task automatic t_sref();
    cm(1'b1, srpd_pkg::CMD_PRE, 1'b0, 3'h0, 16'h0400);
    cm(1'b0, srpd_pkg::CMD_REF, 1'b0, 3'h0, 16'h0);
    step(1);
    chk("sr state", 32'h2, 32'(pst));
    chk("sr dll", 32'h0, 32'(dll));
    step(2);
    chk("sr iref", 32'h1, 32'(iref));
    cm(1'b0, srpd_pkg::CMD_ACT, 1'b1, 3'h1, 16'h0);
    step(2);
    chk("sr rtt", 32'h0, 32'(rtt));
    chk("sr hold", 32'h2, 32'(pst));
    chk("sr rx", 32'h0, 32'(rx));
    cm(1'b1, srpd_pkg::CMD_NOP, 1'b0, 3'h0, 16'h0);
    step(1);
    chk("srx dllrst", 32'h1, 32'(dllr));
    chk("srx state", 32'h1, 32'(pst));
    rdc(srpd_pkg::REG_REFCNT, 32'h1, "refcnt");
    cm(1'b1, srpd_pkg::CMD_REF, 1'b0, 3'h0, 16'h0);
    step(1);
    chk("ref cke high", 32'h1, 32'(pst));
  endtask
  // Power-down kinds, receiver shut-off, exit and device reset
  task automatic t_pdn();
    cm(1'b1, srpd_pkg::CMD_MRS, 1'b0, 3'h0, 16'h0);
    cm(1'b0, srpd_pkg::CMD_NOP, 1'b0, 3'h0, 16'h0);
    step(1);
    chk("pd pre", 32'h3, 32'(pst));
    chk("pd dll", 32'h0, 32'(dll));
    step(1);
    chk("pd rx", 32'h0, 32'(rx));
    cm(1'b1, srpd_pkg::CMD_NOP, 1'b0, 3'h0, 16'h0);
    step(1);
    chk("pdx dll", 32'h1, 32'(dll));
    cm(1'b1, srpd_pkg::CMD_ACT, 1'b0, 3'h2, 16'h0);
    cm(1'b0, srpd_pkg::CMD_NOP, 1'b0, 3'h0, 16'h0);
    step(1);
    chk("pd act", 32'h4, 32'(pst));
    chk("pd act dll", 32'h1, 32'(dll));
    srpd_ctl_i.set_rst(1'b0);
    step(1);
    chk("pd reset", 32'h0, 32'(pst));
    cm(1'b1, srpd_pkg::CMD_NOP, 1'b0, 3'h0, 16'h0);
    srpd_ctl_i.set_rst(1'b1);
    step(1);
    chk("rst exit", 32'h1, 32'(pst));
    rdc(srpd_pkg::REG_STATUS, 32'h51, "rst status");
  endtask
  // ==========================================================================
  // Verdict, watchdog and main sequence
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #1ms;
    fail_count++;
    give_verdict();
  end
  initial begin
    {awv, wv, bry, arv, rry, awa, ara, wd} = '0;
    srst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    step(2);
    rdc(srpd_pkg::REG_STATUS, 32'h51, "status");
    rdc(srpd_pkg::REG_REFCFG, 32'h4E, "refcfg");
    axw(srpd_pkg::REG_REFCFG, 32'h0);
    rdc(srpd_pkg::REG_REFCFG, 32'h1, "refcfg min");
    axw(srpd_pkg::REG_REFCFG, 32'h40);
    axw(srpd_pkg::REG_STATUS, 32'hFFFF);
    rdc(srpd_pkg::REG_STATUS, 32'h51, "status ro");
    rtt_case(3'h1, 16'h0004, 1'b1);
    rtt_case(3'h1, 16'h0000, 1'b0);
    rtt_case(3'h2, 16'h0400, 1'b1);
    t_sref();
    t_pdn();
    give_verdict();
  end
endmodule
